// *** rtl/scan_tap_pkg.sv ***
package scan_tap_pkg;
  localparam int IR_WIDTH = 3;
  localparam int ID_WIDTH = 32;
  localparam logic [2:0] IR_EXTERNAL = 3'h0;
  localparam logic [2:0] IR_IDENT = 3'h1;
  localparam logic [2:0] IR_SAMPLE_Z = 3'h2;
  localparam logic [2:0] IR_RSVD_A = 3'h3;
  localparam logic [2:0] IR_SAMPLE = 3'h4;
  localparam logic [2:0] IR_PRIVATE = 3'h5;
  localparam logic [2:0] IR_RSVD_B = 3'h6;
  localparam logic [2:0] IR_BYPASS = 3'h7;
  localparam logic [1:0] IR_CAPTURE_LOW = 2'h1;
  localparam logic ID_PRESENCE = 1'h1;
  localparam int ID_MAKER_LSB = 1;
  localparam int ID_MAKER_MSB = 11;
  localparam int RESET_TMS_EDGES = 5;
  typedef enum logic [15:0] {
    ST_RESET = 16'h0001, ST_IDLE = 16'h0002, ST_SEL_DR = 16'h0004, ST_CAP_DR = 16'h0008,
    ST_SHIFT_DR = 16'h0010, ST_EXIT1_DR = 16'h0020, ST_PAUSE_DR = 16'h0040, ST_EXIT2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100, ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SHIFT_IR = 16'h0800,
    ST_EXIT1_IR = 16'h1000, ST_PAUSE_IR = 16'h2000, ST_EXIT2_IR = 16'h4000, ST_UPD_IR = 16'h8000
  } tap_state_e;
endpackage

// *** rtl/tap_edge_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
// Two-flop synchroniser plus edge detect on the second stage
module tap_edge_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out,
  output logic rise_out,
  output logic fall_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic last;
  } sync_s;
  sync_s s_q, s_d;
  always_comb begin
    s_d = s_q;
    s_d.meta = async_in;
    s_d.sync = s_q.meta;
    s_d.last = s_q.sync[0];
  end
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      // Pins idle high on pull-ups; avoids a false edge after reset
      s_q <= '1;
    end else begin
      s_q <= s_d;
    end
  end
  assign sync_out = s_q.sync;
  assign rise_out = s_q.sync[0] & ~s_q.last;
  assign fall_out = ~s_q.sync[0] & s_q.last;
endmodule
`default_nettype wire

// *** rtl/sram_boundary_scan_tap.sv ***
`timescale 1ns/10ps
`default_nettype none
// Function
// - Identification instruction loads 32-bit constant at Capture-DR, shifts it in Shift-DR.
// - Identification bit 0 leaves first on test data output.
// - Identification bit 0 is 1; bits 11..1 hold maker code.
// - Capture-IR loads 01 into the two low instruction bits.
// - Shift-IR places instruction register between data in and out.
// - New instruction becomes active only at Update-IR.
// - Code 111 places one-bit bypass register in path.
// - Reserved codes 011 and 110 act exactly as bypass.
// - Code 100 captures pins into boundary register, then shifts it.
// - Boundary cells without pin capture their fixed default.
// - Code 000 does not isolate RAM inputs from the core.
// - Code 000 drives boundary contents onto data outputs on falling edge.
// - Code 000 captures pins and defaults at Capture-DR rising edge.
// - Identification code 001 active after power-up and in Test-Logic-Reset.
// - Code 010 forces RAM outputs high-Z and scans boundary register.
// - Instruction codes are 3-bit binary, MSB leftmost.
// - Instruction register is three bits, loaded only while in the path.
// - Five rising edges with mode select high reach Test-Logic-Reset.
// - Inputs sampled on rising test clock, output changes on falling.
// - Bypass register is a single flip-flop.
module sram_boundary_scan_tap #(
  parameter int BSR_LEN = 8,
  parameter logic [BSR_LEN-1:0] BSR_PIN_MASK = 8'h3F,
  parameter logic [BSR_LEN-1:0] BSR_DEFAULT = 8'hC0,
  parameter logic [10:0] MAKER_CODE = 11'h2A5, // Arbitrary value
  parameter logic [19:0] ID_UPPER = 20'h00000
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  input wire logic [BSR_LEN-1:0] pin_state_in,
  output logic tdo_out,
  output logic tdo_oe_out,
  output logic [BSR_LEN-1:0] bsr_drive_out,
  output logic bsr_drive_en_out,
  output logic ram_out_hiz_out,
  output logic [2:0] active_ir_out
);
  initial begin
    if (BSR_LEN < 2 || BSR_LEN > 1024) begin
      $error("BSR_LEN out of range");
    end
    if (scan_tap_pkg::IR_WIDTH != 3) begin
      $error("IR_WIDTH must be 3");
    end
  end

  localparam logic [31:0] ID_WORD = {ID_UPPER, MAKER_CODE, scan_tap_pkg::ID_PRESENCE};

  typedef struct packed {
    scan_tap_pkg::tap_state_e st;
    logic [2:0] ir_shift;
    logic [2:0] ir_act;
    logic byp;
    logic [31:0] id_sr;
    logic [BSR_LEN-1:0] bsr;
    logic [BSR_LEN-1:0] bsr_upd;
    logic [2:0] tms_ones;
    logic tdo;
    logic tdo_oe;
    logic drive_en;
    logic hiz;
    logic [BSR_LEN-1:0] pin_meta;
    logic [BSR_LEN-1:0] pin_sync;
  } tap_s;

  tap_s s_q, s_d;
  logic [2:0] syn;
  logic tck_rise, tck_fall;
  logic tms_s, tdi_s;

  tap_edge_sync #(.WIDTH(3)) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .async_in({tdi_in, tms_in, tck_in}),
    .sync_out(syn),
    .rise_out(tck_rise),
    .fall_out(tck_fall)
  );
  assign tms_s = syn[1];
  assign tdi_s = syn[2];

  // Reserved, private and bypass codes share bypass path
  function automatic logic is_bypass(input logic [2:0] code);
    is_bypass = (code == scan_tap_pkg::IR_BYPASS) || (code == scan_tap_pkg::IR_RSVD_A) ||
      (code == scan_tap_pkg::IR_RSVD_B) || (code == scan_tap_pkg::IR_PRIVATE);
  endfunction

  function automatic logic is_bsr(input logic [2:0] code);
    is_bsr = (code == scan_tap_pkg::IR_EXTERNAL) || (code == scan_tap_pkg::IR_SAMPLE) ||
      (code == scan_tap_pkg::IR_SAMPLE_Z);
  endfunction

  function automatic scan_tap_pkg::tap_state_e next_st(input scan_tap_pkg::tap_state_e cur, input logic m);
    case (cur)
      scan_tap_pkg::ST_RESET: next_st = m ? scan_tap_pkg::ST_RESET : scan_tap_pkg::ST_IDLE;
      scan_tap_pkg::ST_IDLE: next_st = m ? scan_tap_pkg::ST_SEL_DR : scan_tap_pkg::ST_IDLE;
      scan_tap_pkg::ST_SEL_DR: next_st = m ? scan_tap_pkg::ST_SEL_IR : scan_tap_pkg::ST_CAP_DR;
      scan_tap_pkg::ST_CAP_DR: next_st = m ? scan_tap_pkg::ST_EXIT1_DR : scan_tap_pkg::ST_SHIFT_DR;
      scan_tap_pkg::ST_SHIFT_DR: next_st = m ? scan_tap_pkg::ST_EXIT1_DR : scan_tap_pkg::ST_SHIFT_DR;
      scan_tap_pkg::ST_EXIT1_DR: next_st = m ? scan_tap_pkg::ST_UPD_DR : scan_tap_pkg::ST_PAUSE_DR;
      scan_tap_pkg::ST_PAUSE_DR: next_st = m ? scan_tap_pkg::ST_EXIT2_DR : scan_tap_pkg::ST_PAUSE_DR;
      scan_tap_pkg::ST_EXIT2_DR: next_st = m ? scan_tap_pkg::ST_UPD_DR : scan_tap_pkg::ST_SHIFT_DR;
      scan_tap_pkg::ST_UPD_DR: next_st = m ? scan_tap_pkg::ST_SEL_DR : scan_tap_pkg::ST_IDLE;
      scan_tap_pkg::ST_SEL_IR: next_st = m ? scan_tap_pkg::ST_RESET : scan_tap_pkg::ST_CAP_IR;
      scan_tap_pkg::ST_CAP_IR: next_st = m ? scan_tap_pkg::ST_EXIT1_IR : scan_tap_pkg::ST_SHIFT_IR;
      scan_tap_pkg::ST_SHIFT_IR: next_st = m ? scan_tap_pkg::ST_EXIT1_IR : scan_tap_pkg::ST_SHIFT_IR;
      scan_tap_pkg::ST_EXIT1_IR: next_st = m ? scan_tap_pkg::ST_UPD_IR : scan_tap_pkg::ST_PAUSE_IR;
      scan_tap_pkg::ST_PAUSE_IR: next_st = m ? scan_tap_pkg::ST_EXIT2_IR : scan_tap_pkg::ST_PAUSE_IR;
      scan_tap_pkg::ST_EXIT2_IR: next_st = m ? scan_tap_pkg::ST_UPD_IR : scan_tap_pkg::ST_SHIFT_IR;
      scan_tap_pkg::ST_UPD_IR: next_st = m ? scan_tap_pkg::ST_SEL_DR : scan_tap_pkg::ST_IDLE;
      default: next_st = scan_tap_pkg::ST_RESET;
    endcase
  endfunction

  always_comb begin
    s_d = s_q;
    // RAM pins cross into this domain through two flops
    s_d.pin_meta = pin_state_in;
    s_d.pin_sync = s_q.pin_meta;
    if (tck_rise) begin
      s_d.st = next_st(s_q.st, tms_s);
      // Counts consecutive high samples; guarantees reset
      if (tms_s) begin
        if (s_q.tms_ones < 3'(scan_tap_pkg::RESET_TMS_EDGES)) begin
          s_d.tms_ones = s_q.tms_ones + 3'h1;
        end
        if (s_q.tms_ones >= 3'(scan_tap_pkg::RESET_TMS_EDGES - 1)) begin
          s_d.st = scan_tap_pkg::ST_RESET;
        end
      end else begin
        s_d.tms_ones = 3'h0;
      end
      case (s_q.st)
        scan_tap_pkg::ST_RESET: begin
          s_d.ir_act = scan_tap_pkg::IR_IDENT;
        end
        scan_tap_pkg::ST_CAP_IR: begin
          s_d.ir_shift = {s_q.ir_act[2], scan_tap_pkg::IR_CAPTURE_LOW};
        end
        scan_tap_pkg::ST_SHIFT_IR: begin
          s_d.ir_shift = {tdi_s, s_q.ir_shift[2:1]};
        end
        scan_tap_pkg::ST_CAP_DR: begin
          if (s_q.ir_act == scan_tap_pkg::IR_IDENT) begin
            s_d.id_sr = ID_WORD;
          end
          if (is_bsr(s_q.ir_act)) begin
            s_d.bsr = (s_q.pin_sync & BSR_PIN_MASK) | (BSR_DEFAULT & ~BSR_PIN_MASK);
          end
          s_d.byp = 1'b0;
        end
        scan_tap_pkg::ST_SHIFT_DR: begin
          if (s_q.ir_act == scan_tap_pkg::IR_IDENT) begin
            s_d.id_sr = {tdi_s, s_q.id_sr[31:1]};
          end else if (is_bsr(s_q.ir_act)) begin
            s_d.bsr = {tdi_s, s_q.bsr[BSR_LEN-1:1]};
          end else begin
            s_d.byp = tdi_s;
          end
        end
        default: begin
        end
      endcase
    end
    if (tck_fall) begin
      s_d.tdo_oe = 1'b0;
      s_d.tdo = 1'b0;
      if (s_q.st == scan_tap_pkg::ST_SHIFT_IR) begin
        s_d.tdo = s_q.ir_shift[0];
        s_d.tdo_oe = 1'b1;
      end else if (s_q.st == scan_tap_pkg::ST_SHIFT_DR) begin
        s_d.tdo_oe = 1'b1;
        if (s_q.ir_act == scan_tap_pkg::IR_IDENT) begin
          s_d.tdo = s_q.id_sr[0];
        end else if (is_bsr(s_q.ir_act)) begin
          s_d.tdo = s_q.bsr[0];
        end else begin
          s_d.tdo = s_q.byp;
        end
      end
      // Parallel drive under external test, on the falling edge in Update-IR or Update-DR
      if (s_q.st == scan_tap_pkg::ST_UPD_IR || s_q.st == scan_tap_pkg::ST_UPD_DR) begin
        s_d.bsr_upd = s_q.bsr;
      end
      if (s_q.st == scan_tap_pkg::ST_UPD_IR) begin
        s_d.ir_act = s_q.ir_shift;
      end
      s_d.drive_en = (s_d.ir_act == scan_tap_pkg::IR_EXTERNAL);
      s_d.hiz = (s_d.ir_act == scan_tap_pkg::IR_SAMPLE_Z);
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_q <= '{st: scan_tap_pkg::ST_RESET, ir_shift: scan_tap_pkg::IR_IDENT, ir_act: scan_tap_pkg::IR_IDENT,
               byp: 1'b0, id_sr: 32'h0, bsr: '0, bsr_upd: '0, tms_ones: 3'h0, tdo: 1'b0,
               tdo_oe: 1'b0, drive_en: 1'b0, hiz: 1'b0, pin_meta: '0, pin_sync: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign tdo_out = s_q.tdo;
  assign tdo_oe_out = s_q.tdo_oe;
  assign bsr_drive_out = s_q.bsr_upd;
  assign bsr_drive_en_out = s_q.drive_en;
  assign ram_out_hiz_out = s_q.hiz;
  assign active_ir_out = s_q.ir_act;

  a_ir_update: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (tck_fall && s_q.st == scan_tap_pkg::ST_UPD_IR) |=> s_q.ir_act == $past(s_q.ir_shift))
    else $error("instruction not updated");
  a_ir_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (s_q.st != scan_tap_pkg::ST_UPD_IR && s_q.st != scan_tap_pkg::ST_RESET) |=> $stable(s_q.ir_act))
    else $error("instruction changed early");
  a_tlr_ident: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (tck_rise && s_q.st == scan_tap_pkg::ST_RESET) |=> s_q.ir_act == scan_tap_pkg::IR_IDENT)
    else $error("reset instruction not identification");
  a_capir_low: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (tck_rise && s_q.st == scan_tap_pkg::ST_CAP_IR) |=> s_q.ir_shift[1:0] == scan_tap_pkg::IR_CAPTURE_LOW)
    else $error("capture-IR pattern wrong");
  a_id_capture: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (tck_rise && s_q.st == scan_tap_pkg::ST_CAP_DR && s_q.ir_act == scan_tap_pkg::IR_IDENT)
    |=> s_q.id_sr == ID_WORD && s_q.id_sr[0] == 1'b1) else $error("id capture wrong");
  a_tms_reset: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (tck_rise && tms_s && s_q.tms_ones == 3'h4) |=> s_q.st == scan_tap_pkg::ST_RESET)
    else $error("five high samples did not reset");
  a_bypass_tdo: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (tck_fall && s_q.st == scan_tap_pkg::ST_SHIFT_DR && is_bypass(s_q.ir_act))
    |=> s_q.tdo == $past(s_q.byp) && s_q.tdo_oe) else $error("bypass output wrong");
  a_tdo_fall: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    !tck_fall |=> $stable(s_q.tdo))
    else $error("tdo changed off falling edge");
  a_hiz_mode: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    tck_fall |=> s_q.hiz == (s_q.ir_act == scan_tap_pkg::IR_SAMPLE_Z))
    else $error("high-Z mode wrong");
  a_tdo_oe_shift: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    tck_fall |=> s_q.tdo_oe == ($past(s_q.st) == scan_tap_pkg::ST_SHIFT_IR || $past(s_q.st) == scan_tap_pkg::ST_SHIFT_DR))
    else $error("tdo enable wrong");
  a_id_shift: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (tck_rise && s_q.st == scan_tap_pkg::ST_SHIFT_DR && s_q.ir_act == scan_tap_pkg::IR_IDENT)
    |=> s_q.id_sr == $past({tdi_s, s_q.id_sr[31:1]})) else $error("id shift wrong");
  a_bsr_pins: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (tck_rise && s_q.st == scan_tap_pkg::ST_CAP_DR && is_bsr(s_q.ir_act))
    |=> (s_q.bsr & BSR_PIN_MASK) == ($past(s_q.pin_sync) & BSR_PIN_MASK)) else $error("pin capture wrong");
  a_bsr_default: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (tck_rise && s_q.st == scan_tap_pkg::ST_CAP_DR && is_bsr(s_q.ir_act))
    |=> (s_q.bsr & ~BSR_PIN_MASK) == (BSR_DEFAULT & ~BSR_PIN_MASK)) else $error("default cells wrong");
  a_bypass_cap: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (tck_rise && s_q.st == scan_tap_pkg::ST_CAP_DR) |=> !s_q.byp)
    else $error("bypass capture not zero");
  a_drive_ext: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    tck_fall |=> s_q.drive_en == (s_q.ir_act == scan_tap_pkg::IR_EXTERNAL))
    else $error("external drive enable wrong");
  a_upd_latch: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (tck_fall && (s_q.st == scan_tap_pkg::ST_UPD_IR || s_q.st == scan_tap_pkg::ST_UPD_DR))
    |=> s_q.bsr_upd == $past(s_q.bsr)) else $error("parallel latch wrong");
  a_ir_shift: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (tck_rise && s_q.st == scan_tap_pkg::ST_SHIFT_IR) |=> s_q.ir_shift == $past({tdi_s, s_q.ir_shift[2:1]}))
    else $error("instruction shift wrong");
  a_ir_path_only: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (s_q.st != scan_tap_pkg::ST_CAP_IR && s_q.st != scan_tap_pkg::ST_SHIFT_IR) |=> $stable(s_q.ir_shift))
    else $error("instruction register loaded out of path");
  a_tlr_stay: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (tck_rise && tms_s && s_q.st == scan_tap_pkg::ST_RESET) |=> s_q.st == scan_tap_pkg::ST_RESET)
    else $error("left reset with mode select high");
  a_tms_clear: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (tck_rise && !tms_s) |=> s_q.tms_ones == 3'h0)
    else $error("high count not cleared");
  a_tdo_bsr: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (tck_fall && s_q.st == scan_tap_pkg::ST_SHIFT_DR && is_bsr(s_q.ir_act))
    |=> s_q.tdo == $past(s_q.bsr[0])) else $error("boundary output wrong");
  a_tdo_ir: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (tck_fall && s_q.st == scan_tap_pkg::ST_SHIFT_IR) |=> s_q.tdo == $past(s_q.ir_shift[0]))
    else $error("instruction output wrong");
  a_tdo_id: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (tck_fall && s_q.st == scan_tap_pkg::ST_SHIFT_DR && s_q.ir_act == scan_tap_pkg::IR_IDENT)
    |=> s_q.tdo == $past(s_q.id_sr[0])) else $error("id output wrong");
  a_bsr_shift: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (tck_rise && s_q.st == scan_tap_pkg::ST_SHIFT_DR && is_bsr(s_q.ir_act))
    |=> s_q.bsr == $past({tdi_s, s_q.bsr[BSR_LEN-1:1]})) else $error("boundary shift wrong");
  a_byp_shift: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (tck_rise && s_q.st == scan_tap_pkg::ST_SHIFT_DR && is_bypass(s_q.ir_act))
    |=> s_q.byp == $past(tdi_s)) else $error("bypass shift wrong");
  a_id_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (s_q.ir_act != scan_tap_pkg::IR_IDENT) |=> $stable(s_q.id_sr))
    else $error("device_identification moved off identification");
  a_bsr_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (s_q.ir_act == scan_tap_pkg::IR_IDENT) |=> $stable(s_q.bsr))
    else $error("boundary register moved under identification");
  a_hiz_no_drive: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    !(s_q.hiz && s_q.drive_en))
    else $error("high-Z and drive together");
endmodule
`default_nettype wire

// *** dv/scan_host.sv ***
`timescale 1ns/10ps
`default_nettype none
// Scan controller model: one TCK period is 8 system clocks, TCK idles high
module scan_host (
  input wire logic clk_sys_in,
  input wire logic tdo_in,
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out
);
  initial begin
    tck_out = 1'h1;
    tms_out = 1'h1;
    tdi_out = 1'h1;
  end
  // TMS and TDI move with the falling edge, TDO read after the rising one
  task automatic bit_io(input logic tms, input logic tdi, output logic tdo);
    @(posedge clk_sys_in);
    tck_out <= 1'h0;
    tms_out <= tms;
    tdi_out <= tdi;
    repeat (4) @(posedge clk_sys_in);
    tck_out <= 1'h1;
    repeat (2) @(posedge clk_sys_in);
    #1 tdo = tdo_in;
    @(posedge clk_sys_in);
    #1;
  endtask
  // TMS sequence, first bit in the LSB
  task automatic walk(input logic [7:0] seq, input int n);
    logic b;
    for (int i = 0; i < n; i++) bit_io(seq[i], 1'h1, b);
  endtask
  task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
    logic b;
    dout = 32'h0;
    for (int i = 0; i < n; i++) begin
      bit_io(i == n - 1, din[i], b);
      dout[i] = b;
    end
  endtask
  // Idle to Shift-DR, shift, then Update-DR and back to Idle
  task automatic dr(input int n, input logic [31:0] din, output logic [31:0] dout);
    walk(8'h01, 3);
    shift(n, din, dout);
    walk(8'h01, 2);
  endtask
endmodule
`default_nettype wire

// *** dv/test_sram_boundary_scan_tap.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_sram_boundary_scan_tap;
  localparam logic [10:0] MAKER = 11'h2A5; // Arbitrary value
  logic clk_sys_in = 1'h0;
  logic rst_b_in = 1'h0;
  logic [7:0] pins = 8'h5A;
  logic tck, tms, tdi, tdo, tdo_oe, drive_en, hiz;
  logic [7:0] drive;
  logic [2:0] active_ir;
  logic [31:0] got;
  int err_total = 0;
  int samples_checked = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  scan_host i_host (.clk_sys_in(clk_sys_in), .tdo_in(tdo), .tck_out(tck), .tms_out(tms), .tdi_out(tdi));
  sram_boundary_scan_tap #(.MAKER_CODE(MAKER)) i_dut (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
    .pin_state_in(pins), .tdo_out(tdo), .tdo_oe_out(tdo_oe), .bsr_drive_out(drive),
    .bsr_drive_en_out(drive_en), .ram_out_hiz_out(hiz), .active_ir_out(active_ir));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic load_ir(input logic [2:0] code);
    logic [31:0] cap;
    logic [2:0] prev;
    prev = active_ir;
    i_host.walk(8'h03, 4);
    i_host.shift(3, {29'h0, code}, cap);
    chk({30'h0, cap[1:0]}, 32'h1);
    chk({29'h0, active_ir}, {29'h0, prev});
    i_host.walk(8'h01, 2);
    chk({29'h0, active_ir}, {29'h0, code});
  endtask
  task automatic t_reset;
    chk({29'h0, active_ir}, 32'h1);
    chk({31'h0, tdo_oe}, 32'h0);
    i_host.walk(8'h00, 1);
    $display("test reset done");
  endtask
  task automatic t_ident;
    i_host.dr(32, 32'h0, got);
    chk(got, {20'h00000, MAKER, 1'h1});
    $display("test ident done");
  endtask
  task automatic t_bypass;
    logic [2:0] codes [4] = '{3'h3, 3'h5, 3'h6, 3'h7};
    for (int i = 0; i < 4; i++) begin
      load_ir(codes[i]);
      i_host.dr(4, 32'hD, got);
      chk(got, 32'hA);
    end
    $display("test bypass done");
  endtask
  task automatic t_sample;
    load_ir(3'h4);
    i_host.dr(8, 32'h3C, got);
    chk(got, 32'hDA);
    $display("test sample done");
  endtask
  task automatic t_extest;
    @(posedge clk_sys_in);
    pins <= 8'hA5;
    load_ir(3'h0);
    chk({31'h0, drive_en}, 32'h1);
    chk({24'h0, drive}, 32'h3C);
    i_host.dr(8, 32'h0, got);
    chk(got, 32'hE5);
    chk({24'h0, drive}, 32'h0);
    $display("test extest done");
  endtask
  task automatic t_hiz;
    load_ir(3'h2);
    chk({31'h0, hiz}, 32'h1);
    chk({31'h0, drive_en}, 32'h0);
    i_host.dr(8, 32'h0, got);
    chk(got, 32'hE5);
    $display("test hiz done");
  endtask
  task automatic t_tlr;
    i_host.walk(8'h1F, 5);
    chk({29'h0, active_ir}, 32'h1);
    chk({31'h0, hiz}, 32'h0);
    i_host.walk(8'h00, 1);
    i_host.dr(32, 32'h0, got);
    chk(got, {20'h00000, MAKER, 1'h1});
    $display("test tlr done");
  endtask
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_sys_in);
    rst_b_in <= 1'h1;
    repeat (3) @(posedge clk_sys_in);
    t_reset;
    t_ident;
    t_bypass;
    t_sample;
    t_extest;
    t_hiz;
    t_tlr;
    final_report;
  end
  // About 250 TCK periods expected; allow ten times that
  initial begin
    #200000;
    err_total++;
    final_report;
  end
endmodule
`default_nettype wire
